// ---- hw/fbs_pkg.sv ----
// Constants, types and register map of the flag-branch/bit-op/shift unit
// Assumes one core clock and an Avalon-MM register port
package fbs_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int          ADDR_W    = 7;
   localparam logic [6:0]  ADDR_CMD  = 7'h00;
   localparam logic [6:0]  ADDR_PC   = 7'h04;
   localparam logic [6:0]  ADDR_FLAG = 7'h08;
   localparam logic [6:0]  ADDR_WREG = 7'h0c;
   localparam logic [6:0]  ADDR_STAT = 7'h10;
   localparam int          IO_BASE_B = 6;
   localparam int          IO_DEPTH  = 16;
   localparam int          IO_AW     = 4;

   // ----------------------------------------
   // Status flag positions
   // ----------------------------------------
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;

   // ----------------------------------------
   // Command and status fields
   // ----------------------------------------
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_K_LSB    = 5;
   localparam int CMD_SEL_LSB  = 12;
   localparam int CMD_PORT_LSB = 15;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_TAKEN   = 1;
   localparam int STAT_CYC_LSB = 8;

   // ----------------------------------------
   // Reset values and cycle counts
   // ----------------------------------------
   localparam logic [7:0] FLAG_RST  = 8'h00;
   localparam logic [7:0] WREG_RST  = 8'h00;
   localparam logic [7:0] IO_RST    = 8'h00;
   localparam logic [3:0] CYC_BR_NT = 4'h1;
   localparam logic [3:0] CYC_BR_T  = 4'h2;
   localparam logic [3:0] CYC_IO    = 4'h2;
   localparam logic [3:0] CYC_SHIFT = 4'h1;

   typedef enum logic [4:0] {
      OP_BR_NEG   = 5'h00, OP_BR_POS   = 5'h01, OP_BR_SGE = 5'h02,
      OP_BR_SLT   = 5'h03, OP_BR_HCS   = 5'h04, OP_BR_HCC = 5'h05,
      OP_BR_TBS   = 5'h06, OP_BR_TBC   = 5'h07, OP_BR_OVS = 5'h08,
      OP_BR_OVC   = 5'h09, OP_BR_IEN   = 5'h0a, OP_BR_IDS = 5'h0b,
      OP_BR_IDXS  = 5'h0c, OP_BR_IDXC  = 5'h0d, OP_IO_SET = 5'h0e,
      OP_IO_CLR   = 5'h0f, OP_SHL      = 5'h10, OP_SHR    = 5'h11
   } fbs_op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } fbs_state_t;

   typedef struct packed {
      logic [3:0] port;
      logic [2:0] sel;
      logic [6:0] k;
      logic [4:0] op;
   } fbs_cmd_t;

endpackage

// ---- hw/fbs_unit.sv ----
// Flag-tested branches, I/O bit set/clear and logical shifts
// Assumes an Avalon-MM master with waitrequest on the register port
//
// Notes on behaviour
// - signed ge on N^V=0, lt on 1
// - half-carry branches on H=1 or H=0
// - transfer-bit branches on T=1 or T=0
// - overflow branches on V=1 or V=0
// - interrupt branches on I=1 or I=0
// - taken gives PC+k+1, flags kept, 1/2 cycles
// - I/O bit set writes 1, two cycles
// - I/O bit clear writes 0, two cycles
// - left shift fills 0, sets ZCNV, one cycle
// - indexed flag branch, set or cleared form
module fbs_unit #(
   parameter int PC_W = 16
) (
   // Clock and reset
   input  wire logic                          mclk_i,
   input  wire logic                          rst_i,
   // Avalon-MM slave
   input  wire logic [fbs_pkg::ADDR_W-1:0]    avs_address_i,
   input  wire logic                          avs_read_i,
   input  wire logic                          avs_write_i,
   input  wire logic [31:0]                   avs_writedata_i,
   input  wire logic [3:0]                    avs_byteenable_i,
   output logic      [31:0]                   avs_readdata_o,
   output logic                               avs_waitrequest_o,
   // Core state
   output logic      [PC_W-1:0]               pc_o,
   output logic      [7:0]                    flags_o,
   output logic      [7:0]                    wreg_o,
   output logic      [fbs_pkg::IO_DEPTH*8-1:0] io_regs_o,
   output logic                               busy_o
);
   import fbs_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   fbs_state_t        state_ff;
   fbs_state_t        nxt_state;
   logic              step_ff;
   fbs_cmd_t          cmd_ff;
   logic [PC_W-1:0]   pc_ff;
   logic [7:0]        flag_ff;
   logic [7:0]        wreg_ff;
   logic [7:0]        io_ff [IO_DEPTH];
   logic [7:0]        io_hold_ff;
   logic              taken_ff;
   logic [3:0]        cyc_ff;
   logic              rd_ack_ff;
   logic [31:0]       rdata_ff;
   logic [31:0]       nxt_rdata;

   logic              busy;
   logic              wr_ok;
   logic              cmd_wr;
   logic              fire1;
   logic              fire2;
   logic              is_branch;
   logic              is_io;
   logic              is_shift;
   logic              taken;
   logic              need2;
   logic [PC_W-1:0]   target;
   logic [7:0]        sh_res;
   logic              sh_c;
   logic [7:0]        sh_flag;
   logic [7:0]        io_new;
   logic [31:0]       wmask;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   assign busy    = (state_ff == ST_RUN);
   assign wr_ok   = avs_write_i & ~busy;
   assign cmd_wr  = wr_ok & (avs_address_i == ADDR_CMD);
   assign wmask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign avs_waitrequest_o = (avs_read_i & ~rd_ack_ff) | (avs_write_i & busy);
   assign avs_readdata_o    = rdata_ff;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_ack_ff <= 1'b0;
      end else begin
         rd_ack_ff <= avs_read_i & ~rd_ack_ff;
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (avs_address_i[IO_BASE_B]) begin
         nxt_rdata[7:0] = io_ff[avs_address_i[IO_AW+1:2]];
      end else begin
         case (avs_address_i)
            ADDR_CMD:  nxt_rdata[18:0] = cmd_ff;
            ADDR_PC:   nxt_rdata[PC_W-1:0] = pc_ff;
            ADDR_FLAG: nxt_rdata[7:0] = flag_ff;
            ADDR_WREG: nxt_rdata[7:0] = wreg_ff;
            ADDR_STAT: begin
               nxt_rdata[STAT_BUSY]  = busy;
               nxt_rdata[STAT_TAKEN] = taken_ff;
               nxt_rdata[STAT_CYC_LSB+3:STAT_CYC_LSB] = cyc_ff;
            end
            default:   nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read_i & ~rd_ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // Decode and condition test
   // ----------------------------------------
   assign is_branch = (cmd_ff.op <= OP_BR_IDXC);
   assign is_io     = (cmd_ff.op == OP_IO_SET) | (cmd_ff.op == OP_IO_CLR);
   assign is_shift  = (cmd_ff.op == OP_SHL) | (cmd_ff.op == OP_SHR);

   always_comb begin
      case (cmd_ff.op)
         OP_BR_NEG:  taken = flag_ff[FLG_N];
         OP_BR_POS:  taken = ~flag_ff[FLG_N];
         OP_BR_SGE:  taken = ~(flag_ff[FLG_N] ^ flag_ff[FLG_V]);
         OP_BR_SLT:  taken = flag_ff[FLG_N] ^ flag_ff[FLG_V];
         OP_BR_HCS:  taken = flag_ff[FLG_H];
         OP_BR_HCC:  taken = ~flag_ff[FLG_H];
         OP_BR_TBS:  taken = flag_ff[FLG_T];
         OP_BR_TBC:  taken = ~flag_ff[FLG_T];
         OP_BR_OVS:  taken = flag_ff[FLG_V];
         OP_BR_OVC:  taken = ~flag_ff[FLG_V];
         OP_BR_IEN:  taken = flag_ff[FLG_I];
         OP_BR_IDS:  taken = ~flag_ff[FLG_I];
         OP_BR_IDXS: taken = flag_ff[cmd_ff.sel];
         OP_BR_IDXC: taken = ~flag_ff[cmd_ff.sel];
         default:    taken = 1'b0;
      endcase
   end

   assign target = pc_ff + {{(PC_W-7){cmd_ff.k[6]}}, cmd_ff.k} + PC_W'(1);

   always_comb begin
      if (cmd_ff.op == OP_SHL) begin
         sh_res = {wreg_ff[6:0], 1'b0};
         sh_c   = wreg_ff[7];
      end else begin
         sh_res = {1'b0, wreg_ff[7:1]};
         sh_c   = wreg_ff[0];
      end
   end

   always_comb begin
      sh_flag        = flag_ff;
      sh_flag[FLG_C] = sh_c;
      sh_flag[FLG_Z] = (sh_res == 8'h00);
      sh_flag[FLG_N] = sh_res[7];
      sh_flag[FLG_V] = sh_res[7] ^ sh_c;
   end

   always_comb begin
      io_new = io_hold_ff;
      io_new[cmd_ff.sel] = (cmd_ff.op == OP_IO_SET);
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // taken branch or I/O bit op holds a second cycle
   assign need2 = (is_branch & taken) | is_io;
   assign fire1 = busy & ~step_ff;
   assign fire2 = busy & step_ff;

   always_comb begin
      case (state_ff)
         ST_IDLE: nxt_state = cmd_wr ? ST_RUN : ST_IDLE;
         ST_RUN:  nxt_state = (step_ff | ~need2) ? ST_IDLE : ST_RUN;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         step_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         step_ff  <= fire1 & need2;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_ff <= '0;
      end else if (cmd_wr) begin
         cmd_ff <= fbs_cmd_t'(avs_writedata_i[18:0] & wmask[18:0]);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         taken_ff <= 1'b0;
         cyc_ff   <= 4'h0;
      end else if (fire1) begin
         taken_ff <= is_branch & taken;
         if (is_io) begin
            cyc_ff <= CYC_IO;
         end else if (is_shift) begin
            cyc_ff <= CYC_SHIFT;
         end else begin
            cyc_ff <= taken ? CYC_BR_T : CYC_BR_NT;
         end
      end
   end

   // ----------------------------------------
   // Program counter, flags, working register
   // ----------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_ff <= '0;
      end else if (fire2 & is_branch) begin
         pc_ff <= target;
      end else if (wr_ok & (avs_address_i == ADDR_PC)) begin
         pc_ff <= (pc_ff & ~wmask[PC_W-1:0]) | (avs_writedata_i[PC_W-1:0] & wmask[PC_W-1:0]);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_ff <= FLAG_RST;
      end else if (fire1 & is_shift) begin
         flag_ff <= sh_flag;
      end else if (wr_ok & (avs_address_i == ADDR_FLAG) & avs_byteenable_i[0]) begin
         flag_ff <= avs_writedata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wreg_ff <= WREG_RST;
      end else if (fire1 & is_shift) begin
         wreg_ff <= sh_res;
      end else if (wr_ok & (avs_address_i == ADDR_WREG) & avs_byteenable_i[0]) begin
         wreg_ff <= avs_writedata_i[7:0];
      end
   end

   // ----------------------------------------
   // I/O register space
   // ----------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         io_hold_ff <= IO_RST;
      end else if (fire1 & is_io) begin
         io_hold_ff <= io_ff[cmd_ff.port];
      end
   end

   for (genvar gi = 0; gi < IO_DEPTH; gi++) begin : g_io
      logic bus_wr;
      assign bus_wr = wr_ok & avs_address_i[IO_BASE_B] & avs_byteenable_i[0]
                      & (avs_address_i[IO_AW+1:2] == IO_AW'(gi));
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            io_ff[gi] <= IO_RST;
         end else if (fire2 & is_io & (cmd_ff.port == IO_AW'(gi))) begin
            io_ff[gi] <= io_new;
         end else if (bus_wr) begin
            io_ff[gi] <= avs_writedata_i[7:0];
         end
      end
      assign io_regs_o[gi*8+7:gi*8] = io_ff[gi];
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign pc_o    = pc_ff;
   assign flags_o = flag_ff;
   assign wreg_o  = wreg_ff;
   assign busy_o  = busy;

endmodule

// ---- verif/fbs_unit_sva.sv ----
// Checker for fbs_unit: branch, I/O bit and shift timing and results
// Assumes a bind to fbs_unit, one clock and an async high reset
module fbs_unit_sva
   import fbs_pkg::*;
#(
   parameter int PC_W = 16
) (
   // Clock, reset and bus
   input  wire logic                           mclk_i,
   input  wire logic                           rst_i,
   input  wire logic [fbs_pkg::ADDR_W-1:0]     avs_address_i,
   input  wire logic                           avs_write_i,
   input  wire logic [31:0]                    avs_writedata_i,
   input  wire logic                           avs_waitrequest_o,
   // Core state
   input  wire logic [PC_W-1:0]                pc_o,
   input  wire logic [7:0]                     flags_o,
   input  wire logic [7:0]                     wreg_o,
   input  wire logic [fbs_pkg::IO_DEPTH*8-1:0] io_regs_o,
   input  wire logic                           busy_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic            acc;
   logic            acc_ff;
   logic            br;
   fbs_cmd_t        cmd_ff;
   logic [7:0]      w_ff;
   logic [PC_W-1:0] pc_ff;
   assign acc = avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_CMD;
   assign br  = acc_ff && cmd_ff.op <= OP_BR_IDXC;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) acc_ff <= 1'b0;
      else acc_ff <= acc;
   end
   always_ff @(posedge mclk_i) begin
      if (acc) begin
         cmd_ff <= fbs_cmd_t'(avs_writedata_i[18:0]);
         w_ff   <= wreg_o;
         pc_ff  <= pc_o;
      end
   end
   br_flags_a: assert property (br |-> $stable(flags_o) ##1 $stable(flags_o))
      else $error("branch changed flags");
   br_taken_a: assert property (br ##1 busy_o |=> !busy_o &&
      pc_o == pc_ff + {{(PC_W-7){cmd_ff.k[6]}}, cmd_ff.k} + 1'b1) else $error("bad target");
   br_skip_a: assert property (br ##1 !busy_o |-> pc_o == pc_ff)
      else $error("pc moved on skip");
   neg_cond_a: assert property (br && cmd_ff.op == OP_BR_NEG |=> busy_o == flags_o[FLG_N])
      else $error("negative test wrong");
   slt_cond_a: assert property (br && cmd_ff.op == OP_BR_SLT
      |=> busy_o == (flags_o[FLG_N] ^ flags_o[FLG_V])) else $error("signed test wrong");
   io_bit_a: assert property (acc_ff && cmd_ff.op inside {OP_IO_SET, OP_IO_CLR}
      |-> busy_o ##1 busy_o ##1 (!busy_o &&
      io_regs_o[{cmd_ff.port, cmd_ff.sel}] == (cmd_ff.op == OP_IO_SET))) else $error("io bit");
   shl_a: assert property (acc_ff && cmd_ff.op == OP_SHL |=> !busy_o &&
      wreg_o == {w_ff[6:0], 1'b0} && flags_o[FLG_C] == w_ff[7]) else $error("left shift");
   shr_a: assert property (acc_ff && cmd_ff.op == OP_SHR |=> !busy_o &&
      wreg_o == {1'b0, w_ff[7:1]} && flags_o[FLG_C] == w_ff[0]) else $error("right shift");
endmodule

bind fbs_unit fbs_unit_sva #(.PC_W(PC_W)) u_sva (.mclk_i(mclk_i), .rst_i(rst_i),
   .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o), .pc_o(pc_o),
   .flags_o(flags_o), .wreg_o(wreg_o), .io_regs_o(io_regs_o), .busy_o(busy_o));

// ---- verif/fbs_unit_tb.sv ----
// Bench for fbs_unit: branches, I/O bit ops and shifts over Avalon-MM
// Assumes fbs_pkg, fbs_unit and its checker are compiled first
module fbs_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fbs_pkg::*;
   logic         mclk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic [6:0]   avs_address_i = 7'h00;
   logic         avs_read_i = 1'b0;
   logic         avs_write_i = 1'b0;
   logic [31:0]  avs_writedata_i = 32'h0;
   logic [31:0]  avs_readdata_o;
   logic         avs_waitrequest_o;
   logic [15:0]  pc_o;
   logic [7:0]   flags_o;
   logic [7:0]   wreg_o;
   logic [127:0] io_regs_o;
   logic         busy_o;
   logic [31:0]  rd;
   int           error_cnt = 0;
   int           samples_checked = 0;
   always #20 mclk_i = ~mclk_i;
   fbs_unit DUT (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .pc_o(pc_o), .flags_o(flags_o),
      .wreg_o(wreg_o), .io_regs_o(io_regs_o), .busy_o(busy_o));
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 40);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge mclk_i);
      if (n >= 40) begin
         error_cnt++;
         $display("MISMATCH %0t bus timeout", $time);
         close_out();
      end
   endtask
   task automatic rchk(input logic [6:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic cmd(input logic [4:0] o, input logic [6:0] k, input logic [2:0] s,
                      input logic [3:0] p);
      fbs_cmd_t c;
      int       n;
      c = '{port: p, sel: s, k: k, op: o};
      bus(1'b1, ADDR_CMD, 32'(c));
      // Let the command finish before any readback
      n = 0;
      while (busy_o !== 1'b0 && n < 8) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 8) begin
         error_cnt++;
         $display("MISMATCH %0t command never finished", $time);
         close_out();
      end
   endtask
   function automatic logic taken(input logic [4:0] op, input logic [7:0] f,
                                  input logic [2:0] s);
      logic c;
      case (op[4:1])
         4'h0: c = f[FLG_N];
         4'h1: c = ~(f[FLG_N] ^ f[FLG_V]);
         4'h2: c = f[FLG_H];
         4'h3: c = f[FLG_T];
         4'h4: c = f[FLG_V];
         4'h5: c = f[FLG_I];
         default: c = f[s];
      endcase
      return op[0] ? ~c : c;
   endfunction
   task automatic test_reset();
      rchk(ADDR_PC, 32'h0);
      rchk(ADDR_FLAG, 32'(FLAG_RST));
      rchk(7'h7c, 32'(IO_RST));
      bus(1'b1, 7'h30, 32'hffff_ffff);
      rchk(7'h30, 32'h0);
   endtask
   task automatic test_branches();
      logic [7:0] fl [3];
      logic [6:0] k;
      logic [2:0] s;
      logic       tk;
      logic [31:0] pe;
      fl = '{8'h00, 8'h08, 8'hf4};
      for (int o = 0; o < 14; o++) begin
         for (int i = 0; i < 3; i++) begin
            k = o[0] ? 7'h40 : 7'h3f;
            s = 3'(o + i);
            tk = taken(5'(o), fl[i], s);
            bus(1'b1, ADDR_FLAG, 32'(fl[i]));
            bus(1'b1, ADDR_PC, 32'h10);
            cmd(5'(o), k, s, 4'h0);
            pe = tk ? 32'(16'(16'h11 + {{9{k[6]}}, k})) : 32'h10;
            rchk(ADDR_PC, pe);
            rchk(ADDR_FLAG, 32'(fl[i]));
            rchk(ADDR_STAT, 32'({tk ? CYC_BR_T : CYC_BR_NT, 6'h0, tk, 1'b0}));
         end
      end
   endtask
   task automatic test_io();
      logic [7:0] iv [3];
      logic [7:0] e;
      logic [3:0] p;
      logic [2:0] b;
      iv = '{8'ha4, 8'hff, 8'h00};
      bus(1'b1, ADDR_FLAG, 32'ha5);
      for (int i = 0; i < 3; i++) begin
         p = 4'(i * 7 + 1);
         b = 3'(i * 3 + 1);
         e = i[0] ? (iv[i] & ~(8'h01 << b)) : (iv[i] | (8'h01 << b));
         bus(1'b1, {1'b1, p, 2'b00}, 32'(iv[i]));
         cmd(i[0] ? OP_IO_CLR : OP_IO_SET, 7'h00, b, p);
         rchk({1'b1, p, 2'b00}, 32'(e));
         chk(32'(io_regs_o[{p, 3'h0} +: 8]), 32'(e));
         rchk(ADDR_FLAG, 32'ha5);
         bus(1'b0, ADDR_STAT, 32'h0);
         chk(rd & 32'hf01, 32'({CYC_IO, 8'h00}));
      end
   endtask
   task automatic test_shifts();
      logic [7:0] wv [4];
      logic [7:0] r;
      logic [7:0] w;
      logic       c;
      logic       l;
      wv = '{8'h81, 8'h80, 8'h01, 8'h40};
      for (int i = 0; i < 8; i++) begin
         l = i[0];
         w = wv[i / 2];
         r = l ? {w[6:0], 1'b0} : {1'b0, w[7:1]};
         c = l ? w[7] : w[0];
         bus(1'b1, ADDR_FLAG, 32'hff);
         bus(1'b1, ADDR_WREG, 32'(w));
         cmd(l ? OP_SHL : OP_SHR, 7'h00, 3'h0, 4'h0);
         rchk(ADDR_WREG, 32'(r));
         rchk(ADDR_FLAG, 32'({4'hf, r[7] ^ c, r[7], r == 8'h00, c}));
         bus(1'b0, ADDR_STAT, 32'h0);
         chk(rd & 32'hf01, 32'({CYC_SHIFT, 8'h00}));
      end
   endtask
   initial begin
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      test_reset();
      test_branches();
      test_io();
      test_shifts();
      close_out();
   end
endmodule
